// ---- bir_pkg.sv ----
package bir_pkg;

  // ----------------------------------------------------------------
  // sizes and interrupt numbers
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 8;
  localparam int NUM_LEGACY = 16;
  localparam int NUM_ADV = 24;
  localparam int NUM_DYN = 3;
  localparam int ADV_LINE_BASE = 16;
  localparam logic [3:0] IRQ_TIMER = 4'h0;
  localparam logic [3:0] IRQ_KBD = 4'h1;
  localparam logic [3:0] IRQ_CASCADE = 4'h2;
  localparam logic [3:0] IRQ_FLOPPY = 4'h6;
  localparam logic [3:0] IRQ_RTC = 4'h8;
  localparam logic [3:0] IRQ_MOUSE = 4'hc;
  localparam logic [3:0] IRQ_FPU = 4'hd;
  localparam logic [3:0] IRQ_DISK_PRI = 4'he;
  localparam logic [3:0] IRQ_DISK_SEC = 4'hf;
  localparam int LINE_B = 1;
  localparam int LINE_E = 4;

  // ----------------------------------------------------------------
  // reset values and the set of steerable legacy interrupts
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_SERIAL_IRQ = 4'h4;
  localparam logic [3:0] RST_PARALLEL_IRQ = 4'h7;
  localparam logic [3:0] RST_LINE_STEER = 4'h0;
  localparam logic [2:0] RST_DYN_LINE = 3'h0;
  localparam logic [15:0] STEER_ALLOWED = 16'hdef8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic advMode;
    logic [3:0] slot1Int_n;
    logic [3:0] slot2Int_n;
    logic lanIntA_n;
    logic [NUM_DYN-1:0] dynInt_n;
    logic timer;
    logic kbd;
    logic floppy;
    logic rtc;
    logic fpu;
    logic serial;
    logic parallel;
    logic mouse;
    logic mousePresent;
    logic diskPri;
    logic diskPriPresent;
    logic diskSec;
    logic diskSecPresent;
  } bir_pins_t;

  typedef struct packed {
    logic [NUM_LINES-1:0][3:0] lineSteer;
    logic [3:0] serialIrq;
    logic [3:0] parallelIrq;
    logic [NUM_DYN-1:0][2:0] dynLine;
  } bir_cfg_t;

endpackage : bir_pkg

// ---- bir_router.sv ----
`timescale 1ns/10ps
module bir_router (
  input wire logic core_clk, // 250 MHz core clock
  input wire logic sys_rst, // asynchronous reset, active high
  input wire logic clkEn, // freezes all state while low
  input wire bir_pkg::bir_pins_t pins, // board pins, asynchronous to core_clk
  input wire logic cfgWr, // one-cycle strobe loading cfgIn
  input wire bir_pkg::bir_cfg_t cfgIn, // new steering configuration
  output bir_pkg::bir_cfg_t cfg, // steering configuration in force
  output logic [15:0] legacyIrq, // legacy controller inputs, active high
  output logic [23:0] advIrq, // advanced controller inputs, active high
  output logic [7:0] lineActive // shared line levels seen, active high
);
  import bir_pkg::*;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  bir_pins_t syncA;
  bir_pins_t syncP;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= '1;
      syncP <= '1;
    end else if (clkEn) begin
      syncA <= pins;
      syncP <= syncA;
    end
  end

  // ----------------------------------------------------------------
  // steering configuration
  // ----------------------------------------------------------------
  // values outside the steerable set are stored but route nowhere,
  // so in legacy mode software can park a line by writing an unsteerable number; advanced mode still routes it to its fixed input
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        cfg.lineSteer[i] <= RST_LINE_STEER;
      end
      cfg.serialIrq <= RST_SERIAL_IRQ;
      cfg.parallelIrq <= RST_PARALLEL_IRQ;
      for (int d = 0; d < NUM_DYN; d++) begin
        cfg.dynLine[d] <= RST_DYN_LINE;
      end
    end else if (clkEn && cfgWr) begin
      cfg <= cfgIn;
    end
  end

  // ----------------------------------------------------------------
  // shared request lines
  // ----------------------------------------------------------------
  logic [NUM_LINES-1:0] lineAct;

  // wired-or of active-low levels; each source holds until serviced
  always_comb begin
    lineAct = '0;
    lineAct[LINE_B] = !syncP.lanIntA_n;
    for (int k = 0; k < 4; k++) begin
      lineAct[LINE_E + k] = !syncP.slot2Int_n[k];
    end
    lineAct[LINE_E] = lineAct[LINE_E] | !syncP.slot1Int_n[3];
    for (int k = 0; k < 3; k++) begin
      lineAct[LINE_E + 1 + k] = lineAct[LINE_E + 1 + k] | !syncP.slot1Int_n[k];
    end
    for (int d = 0; d < NUM_DYN; d++) begin
      if (!syncP.dynInt_n[d]) begin
        lineAct[cfg.dynLine[d]] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // legacy and advanced mapping
  // ----------------------------------------------------------------
  logic [15:0] fixedIrq;
  logic [15:0] blocked;
  logic [15:0] next_legacyIrq;
  logic [23:0] next_advIrq;

  always_comb begin
    fixedIrq = '0;
    fixedIrq[IRQ_TIMER] = syncP.timer;
    fixedIrq[IRQ_KBD] = syncP.kbd;
    fixedIrq[IRQ_FLOPPY] = syncP.floppy;
    fixedIrq[IRQ_RTC] = syncP.rtc;
    fixedIrq[IRQ_FPU] = syncP.fpu;
    fixedIrq[IRQ_MOUSE] = syncP.mousePresent & syncP.mouse;
    fixedIrq[IRQ_DISK_PRI] = syncP.diskPriPresent & syncP.diskPri;
    fixedIrq[IRQ_DISK_SEC] = syncP.diskSecPresent & syncP.diskSec;
    if (STEER_ALLOWED[cfg.serialIrq]) begin
      fixedIrq[cfg.serialIrq] = fixedIrq[cfg.serialIrq] | syncP.serial;
    end
    if (STEER_ALLOWED[cfg.parallelIrq]) begin
      fixedIrq[cfg.parallelIrq] = fixedIrq[cfg.parallelIrq] | syncP.parallel;
    end
  end

  // a present mouse or disk channel keeps shared lines off its interrupt; serial and parallel can still be steered onto it
  always_comb begin
    blocked = '0;
    blocked[IRQ_MOUSE] = syncP.mousePresent;
    blocked[IRQ_DISK_PRI] = syncP.diskPriPresent;
    blocked[IRQ_DISK_SEC] = syncP.diskSecPresent;
  end

  always_comb begin
    next_legacyIrq = '0;
    next_advIrq = '0;
    if (syncP.advMode) begin
      next_advIrq[15:0] = fixedIrq;
      next_advIrq[23:16] = lineAct;
    end else begin
      next_legacyIrq = fixedIrq;
      for (int i = 0; i < NUM_LINES; i++) begin
        if (lineAct[i] && STEER_ALLOWED[cfg.lineSteer[i]] && !blocked[cfg.lineSteer[i]]) begin
          next_legacyIrq[cfg.lineSteer[i]] = 1'b1;
        end
      end
      next_legacyIrq[IRQ_CASCADE] = |next_legacyIrq[15:8];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      legacyIrq <= '0;
      advIrq <= '0;
      lineActive <= '0;
    end else if (clkEn) begin
      legacyIrq <= next_legacyIrq;
      advIrq <= next_advIrq;
      lineActive <= lineAct;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  legacy_mode_bounds_a: assert property (
    (clkEn && !syncP.advMode) |=> advIrq == '0)
    else $error("advanced inputs active in legacy mode");

  adv_mode_quiet_a: assert property (
    (clkEn && syncP.advMode) |=> legacyIrq == '0)
    else $error("legacy inputs active in advanced mode");

  adv_line_order_a: assert property (
    (clkEn && syncP.advMode) |=> advIrq[23:16] == $past(lineAct))
    else $error("interrupts 16 to 23 do not follow lines a to h");

  cascade_two_a: assert property (
    (clkEn && !syncP.advMode) |=> legacyIrq[2] == (|legacyIrq[15:8]))
    else $error("cascade interrupt does not reflect secondary group");

  fixed_timer_a: assert property (
    (clkEn && !syncP.advMode && syncP.timer && syncP.rtc) |=>
      legacyIrq[0] && legacyIrq[8] && legacyIrq[2])
    else $error("timer or clock interrupt missing");

  serial_steer_a: assert property (
    (clkEn && !syncP.advMode && syncP.serial && STEER_ALLOWED[cfg.serialIrq]) |=>
      legacyIrq[$past(cfg.serialIrq)])
    else $error("serial port interrupt not delivered");

  disk_owner_a: assert property (
    (clkEn && !syncP.advMode && syncP.diskPriPresent && !syncP.diskPri &&
     !syncP.serial && !syncP.parallel) |=> !legacyIrq[14])
    else $error("present disk channel interrupt shared by steering");

  mouse_owner_a: assert property (
    (clkEn && !syncP.advMode && syncP.mousePresent && syncP.mouse) |=> legacyIrq[12])
    else $error("mouse interrupt missing");

  slot_wiring_a: assert property (
    (clkEn && !syncP.slot1Int_n[3]) |=> lineActive[LINE_E])
    else $error("slot 1 fourth request not on line e");

  for (genvar g = 0; g < NUM_LINES; g++) begin : g_steer
    line_steer_a: assert property (
      (clkEn && !syncP.advMode && lineAct[g] && STEER_ALLOWED[cfg.lineSteer[g]] &&
       !blocked[cfg.lineSteer[g]]) |=> legacyIrq[$past(cfg.lineSteer[g])])
      else $error("steered shared line not delivered");
  end

  dyn_route_a: assert property (
    (!syncP.dynInt_n[0]) |-> lineAct[cfg.dynLine[0]])
    else $error("run-time source not on its chosen line");

  shared_same_c: cover property (
    clkEn && !syncP.advMode && lineAct[4] && lineAct[5] &&
    cfg.lineSteer[4] == cfg.lineSteer[5] && STEER_ALLOWED[cfg.lineSteer[4]]);
  adv_slot_c: cover property (clkEn && syncP.advMode && lineAct[7]);
  cascade_c: cover property (clkEn && !syncP.advMode && syncP.rtc ##1 legacyIrq[2]);
  reprogram_c: cover property (clkEn && cfgWr && cfgIn.serialIrq != RST_SERIAL_IRQ);

endmodule : bir_router

// ---- bir_card_model.sv ----
`timescale 1ns/10ps
module bir_card_model (
  input wire logic core_clk, // board clock
  input wire logic slow, // answer a cycle late
  input wire logic [11:0] want, // dyn, lan, slot2, slot1 requests
  output logic [3:0] slot1Int_n, // slot 1 d..a
  output logic [3:0] slot2Int_n, // slot 2 d..a
  output logic lanIntA_n, // network a
  output logic [2:0] dynInt_n // run-time steered sources
);
  logic [11:0] late;
  always_ff @(posedge core_clk) begin
    late <= want;
  end
  // first request of a card on a, then b, c, d; held low while wanted, else pulled high
  assign {dynInt_n, lanIntA_n, slot2Int_n, slot1Int_n} = ~(slow ? late : want);
endmodule : bir_card_model

// ---- test_board_interrupt_routing.sv ----
`timescale 1ns/10ps
module test_board_interrupt_routing;
  import bir_pkg::*;
  typedef struct packed {
    logic [15:0] leg;
    logic [23:0] adv;
    logic [7:0] ln;
    int due;
  } bir_note_t;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfgWr = 1'b0;
  logic clkEn = 1'b1;
  logic slow = 1'b0;
  logic [11:0] want = '0;
  bir_pins_t drv = '0;
  bir_pins_t pins;
  bir_cfg_t cfgIn = '0;
  bir_cfg_t cfg;
  bir_cfg_t cur = {32'h0, 4'h4, 4'h7, 9'h0};
  bir_cfg_t c;
  logic [15:0] legacyIrq;
  logic [23:0] advIrq;
  logic [7:0] lineActive;
  logic [3:0] s1;
  logic [3:0] s2;
  logic lan;
  logic [2:0] dyn;
  logic [3:0] oks [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb};
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 32'h1481;
  bir_note_t q[$];
  bir_note_t seen;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) cyc++;
  always_comb begin
    pins = drv;
    pins.slot1Int_n = s1;
    pins.slot2Int_n = s2;
    pins.lanIntA_n = lan;
    pins.dynInt_n = dyn;
  end
  bir_card_model i_card (.core_clk, .slow, .want, .slot1Int_n(s1), .slot2Int_n(s2),
    .lanIntA_n(lan), .dynInt_n(dyn));
  bir_router i_dut (.core_clk, .sys_rst, .clkEn, .pins, .cfgWr, .cfgIn, .cfg,
    .legacyIrq, .advIrq, .lineActive);
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  function automatic bir_note_t predict(input bir_pins_t p, input bir_cfg_t k);
    bir_note_t n;
    logic [15:0] f;
    logic [15:0] g;
    logic [3:0] s;
    n = '0;
    f = '0;
    g = '0;
    n.ln[LINE_B] = ~p.lanIntA_n;
    for (int i = 0; i < 4; i++) begin
      n.ln[LINE_E+i] = ~p.slot2Int_n[i] | ~p.slot1Int_n[(i+3)%4];
    end
    for (int i = 0; i < NUM_DYN; i++) begin
      if (!p.dynInt_n[i]) n.ln[k.dynLine[i]] = 1'b1;
    end
    f[IRQ_TIMER] = p.timer;
    f[IRQ_KBD] = p.kbd;
    f[IRQ_FLOPPY] = p.floppy;
    f[IRQ_RTC] = p.rtc;
    f[IRQ_FPU] = p.fpu;
    f[IRQ_MOUSE] = p.mouse & p.mousePresent;
    f[IRQ_DISK_PRI] = p.diskPri & p.diskPriPresent;
    f[IRQ_DISK_SEC] = p.diskSec & p.diskSecPresent;
    for (int i = 0; i < NUM_LINES; i++) begin
      s = k.lineSteer[i];
      if (n.ln[i] && STEER_ALLOWED[s] && !(s == IRQ_MOUSE && p.mousePresent)
          && !(s == IRQ_DISK_PRI && p.diskPriPresent)
          && !(s == IRQ_DISK_SEC && p.diskSecPresent)) g[s] = 1'b1;
    end
    if (p.advMode) begin
      n.adv = {n.ln, f};
    end else begin
      n.leg = f | g;
      n.leg[k.serialIrq] |= p.serial;
      n.leg[k.parallelIrq] |= p.parallel;
      n.leg[IRQ_CASCADE] = |n.leg[15:8];
    end
    return n;
  endfunction : predict
  task automatic put_cfg(input bir_cfg_t nc);
    @(negedge core_clk);
    cfgIn = nc;
    cfgWr = 1'b1;
    cur = nc;
    @(negedge core_clk);
    cfgWr = 1'b0;
    chk("cfg", nc, cfg);
  endtask : put_cfg
  task automatic shot(input logic adv);
    bir_pins_t p;
    bir_note_t n;
    logic [11:0] w;
    int k1;
    int k2;
    p = bir_pins_t'(26'($random(seed)));
    p.advMode = adv;
    p.serial &= !adv;
    p.parallel &= !adv;
    k1 = ($random(seed) & 7) % 5;
    k2 = ($random(seed) & 7) % 5;
    w = {4'($random(seed)), 4'((5'h1 << k2) - 1), 4'((5'h1 << k1) - 1)};
    @(negedge core_clk);
    drv = p;
    slow = 1'($random(seed));
    want = w;
    p.slot1Int_n = ~w[3:0];
    p.slot2Int_n = ~w[7:4];
    p.lanIntA_n = ~w[8];
    p.dynInt_n = ~w[11:9];
    n = predict(p, cur);
    n.due = cyc + 5;
    q.push_back(n);
    for (int t = 0; t < 20 && q.size() > 0; t++) @(negedge core_clk);
  endtask : shot
  // --------------------------------
  // result watcher
  // --------------------------------
  always @(negedge core_clk) begin
    if (q.size() > 0 && q[0].due <= cyc) begin
      seen = q.pop_front();
      chk("legacyIrq", seen.leg, legacyIrq);
      chk("advIrq", seen.adv, advIrq);
      chk("lineActive", seen.ln, lineActive);
    end
  end
  initial begin
    #40000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    chk("cfg", cur, cfg);
    c = cur;
    // every steering value, unsteerable ones too, on all lines at once
    for (int v = 0; v < 16; v++) begin
      c.lineSteer = {NUM_LINES{4'(v)}};
      c.serialIrq = oks[v%8];
      c.parallelIrq = oks[(v+3)%8];
      c.dynLine = 9'($random(seed));
      put_cfg(c);
      shot(1'b0);
      shot(1'b0);
    end
    for (int v = 0; v < 40; v++) begin
      c.lineSteer = 32'($random(seed));
      c.dynLine = 9'($random(seed));
      put_cfg(c);
      shot(v[0]);
      shot(v[1]);
    end
    // enable low: pins move, every output must hold the last checked value
    @(negedge core_clk);
    clkEn = 1'b0;
    drv = ~drv;
    repeat (6) @(negedge core_clk);
    chk("frozen legacyIrq", seen.leg, legacyIrq);
    chk("frozen advIrq", seen.adv, advIrq);
    chk("frozen lineActive", seen.ln, lineActive);
    clkEn = 1'b1;
    shot(1'b0);
    wrap_up();
  end
endmodule : test_board_interrupt_routing
